/* rtl/epd_cmd_regs.vh */
`ifndef EPD_CMD_REGS_VH
`define EPD_CMD_REGS_VH

`define EPD_CMD_SLEEP 8'h10
`define EPD_CMD_ENTRY 8'h11
`define EPD_CMD_SWRST 8'h12
`define EPD_CMD_HVDET 8'h14
`define EPD_CMD_SUPPLY 8'h15
`define EPD_CMD_PWPROG 8'h16
`define EPD_CMD_AUTOPROG 8'h17
`define EPD_CMD_TSRC 8'h18
`define EPD_CMD_TWR 8'h1A
`define EPD_CMD_TRD 8'h1B
`define EPD_CMD_EXTS 8'h1C
`define EPD_CMD_ACTIVATE 8'h20
`define EPD_CMD_RAMOPT 8'h21
`define EPD_CMD_SEQOPT 8'h22
`define EPD_CMD_WRBW 8'h24
`define EPD_CMD_STATUS 8'h2F
`define EPD_CMD_PROGMODE 8'h39

`define EPD_RST_ENTRY 3'h3
`define EPD_RST_HVDET 8'h00
`define EPD_RST_SUPPLY 3'h4
`define EPD_RST_TSRC 8'h48
`define EPD_RST_TEMP 8'h7F
`define EPD_RST_EXTS 24'h000000
`define EPD_RST_RAMOPT 16'h0000
`define EPD_RST_SEQOPT 8'hFF

`define EPD_TSRC_INT 8'h80
`define EPD_OPT_ZERO 4'h4
`define EPD_OPT_INV 4'h8
`define EPD_AUTO_SEQ 8'hC7
`define EPD_ST_HV_BIT 5
`define EPD_ST_LOW_BIT 4
`define EPD_ST_BUSY_BIT 2

`define EPD_CLK_HZ 20000000
`define EPD_COOL_MS 10
`define EPD_COOL_CYC ((`EPD_COOL_MS * `EPD_CLK_HZ) / 1000)
`define EPD_STEP_CYC 16
`define EPD_RST_CYC 16
`define EPD_DET_CYC 32
`define EPD_OTP_CYC 64

`define EPD_X_MAX 6'h31
`define EPD_Y_MAX 9'h12B

`endif

/* rtl/epd_cmd_top.v */
`timescale 1ns/10ps
`default_nettype none
`include "epd_cmd_regs.vh"

module epd_cmd_top #(
  parameter COOL_CYC = `EPD_COOL_CYC,
  parameter STEP_CYC = `EPD_STEP_CYC,
  parameter DISP_CYC = `EPD_OTP_CYC,
  parameter CHIP_ID = 2'h1
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire spi_cs_n_i,
  input wire spi_sclk_i,
  input wire spi_mosi_i,
  input wire spi_dc_i,
  output wire spi_miso_o,
  input wire hv_ready_i,
  input wire supply_low_i,
  input wire i2c_done_i,
  input wire [7:0] int_temp_i,
  input wire disp_bw_i,
  input wire disp_red_i,
  output reg disp_bw_o,
  output reg disp_red_o,
  output reg busy_o,
  output reg [1:0] sleep_mode_o,
  output reg clock_on_stage_o,
  output reg analog_on_stage_o,
  output reg [7:0] active_stage_o,
  output reg display_bw_mode_o,
  output reg cascade_link_pin_o,
  output reg otp_prog_o,
  output reg [7:0] otp_area_o,
  output reg [2:0] supply_level_o,
  output reg temp_ext_o,
  output reg i2c_start_o,
  output reg [23:0] ext_sensor_command_o,
  output reg ram_we_o,
  output reg [5:0] ram_x_o,
  output reg [8:0] ram_y_o,
  output reg [7:0] ram_wdata_o,
  output reg spi_overrun_o
);

  // ----------------------------------------------------------------------
  // Operation states
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 6'b000001;
  localparam ST_TIMED = 6'b000010;
  localparam ST_HV = 6'b000100;
  localparam ST_SEQ = 6'b001000;
  localparam ST_I2C = 6'b010000;
  localparam ST_SLEEP = 6'b100000;

  localparam OP_RESET = 2'h0;
  localparam OP_SUPPLY = 2'h1;
  localparam OP_PW = 2'h2;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function [8:0] epd_step;
    input [8:0] val;
    input inc;
    input [8:0] max;
    begin
      if (inc) begin
        epd_step = (val == max) ? 9'h000 : val + 9'h001;
      end else begin
        epd_step = (val == 9'h000) ? max : val - 9'h001;
      end
    end
  endfunction

  function epd_ram_opt;
    input bit_in;
    input [3:0] opt;
    begin
      case (opt)
        `EPD_OPT_ZERO: epd_ram_opt = 1'b0;
        `EPD_OPT_INV: epd_ram_opt = ~bit_in;
        default: epd_ram_opt = bit_in;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Serial link sampling
  // ----------------------------------------------------------------------
  reg [3:0] sync_a;
  reg [3:0] sync_b;
  reg sclk_d;
  reg [2:0] bit_cnt;
  reg [7:0] rx_shift;
  reg rx_valid;
  reg [8:0] rx_word;
  wire rx_ready;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_n_s;
  wire mosi_s;
  wire dc_s;

  assign cs_n_s = sync_b[0];
  assign mosi_s = sync_b[2];
  assign dc_s = sync_b[3];
  assign sclk_rise = sync_b[1] & ~sclk_d;
  assign sclk_fall = ~sync_b[1] & sclk_d;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync_a <= 4'h1;
      sync_b <= 4'h1;
      sclk_d <= 1'b0;
      bit_cnt <= 3'h0;
      rx_shift <= 8'h00;
      rx_valid <= 1'b0;
      rx_word <= 9'h000;
      spi_overrun_o <= 1'b0;
    end else begin
      sync_a <= {spi_dc_i, spi_mosi_i, spi_sclk_i, spi_cs_n_i};
      sync_b <= sync_a;
      sclk_d <= sync_b[1];
      if (rx_valid && rx_ready) begin
        rx_valid <= 1'b0;
      end
      if (cs_n_s) begin
        bit_cnt <= 3'h0;
      end else if (sclk_rise) begin
        rx_shift <= {rx_shift[6:0], mosi_s};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          // A byte that finds the buffer full is lost and flagged.
          if (rx_valid && !rx_ready) begin
            spi_overrun_o <= 1'b1;
          end else begin
            rx_valid <= 1'b1;
            rx_word <= {dc_s, rx_shift[6:0], mosi_s};
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Byte buffer
  // ----------------------------------------------------------------------
  reg [5:0] state;
  wire fifo_valid;
  wire [8:0] fifo_word;
  wire pop;

  epd_fifo #(
    .W(9),
    .D(8),
    .AW(3)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(rx_valid),
    .in_ready_o(rx_ready),
    .in_data_i(rx_word),
    .out_valid_o(fifo_valid),
    .out_ready_i(state == ST_IDLE),
    .out_data_o(fifo_word)
  );

  assign pop = fifo_valid && (state == ST_IDLE);

  // ----------------------------------------------------------------------
  // Command decoder and operation engine
  // ----------------------------------------------------------------------
  reg [7:0] cur_cmd;
  reg [1:0] pidx;
  reg [2:0] entry_direction;
  reg [7:0] hv_detect_setup;
  reg [7:0] temperature_value;
  reg [15:0] update_ram_option;
  reg [7:0] update_sequence_option;
  reg otp_internal;
  reg hv_flag;
  reg low_flag;
  reg [1:0] op_kind;
  reg op_otp;
  reg [7:0] seq_mask;
  reg [2:0] sidx;
  reg [2:0] hv_loops;
  reg [31:0] cnt;
  reg [7:0] rd_shift;
  wire [7:0] dbyte;
  wire dflag;
  wire [8:0] x_next;
  wire [8:0] y_next;
  wire [8:0] x_wrap;
  wire [8:0] y_wrap;
  wire [31:0] cool_len;
  wire [31:0] stage_len;

  assign dbyte = fifo_word[7:0];
  assign dflag = fifo_word[8];
  assign spi_miso_o = rd_shift[7];
  assign x_next = epd_step({3'h0, ram_x_o}, entry_direction[0],
    {3'h0, `EPD_X_MAX});
  assign y_next = epd_step(ram_y_o, entry_direction[1], `EPD_Y_MAX);
  assign x_wrap = entry_direction[0] ? 9'h000 : {3'h0, `EPD_X_MAX};
  assign y_wrap = entry_direction[1] ? 9'h000 : `EPD_Y_MAX;
  assign cool_len = COOL_CYC * ({29'h0, hv_detect_setup[6:4]} + 32'h1);
  assign stage_len = (sidx == 3'h2) ? DISP_CYC : STEP_CYC;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state != ST_IDLE);
    end
  end

  always @(posedge clk_i) begin
    disp_bw_o <= sys_rst_i ? 1'b0 :
      epd_ram_opt(disp_bw_i, update_ram_option[11:8]);
    disp_red_o <= sys_rst_i ? 1'b0 :
      epd_ram_opt(disp_red_i, update_ram_option[15:12]);
  end

  always @(posedge clk_i) begin
    if (sys_rst_i || (state == ST_TIMED && op_kind == OP_RESET &&
        cnt == 32'h0)) begin
      if (sys_rst_i) begin
        sleep_mode_o <= 2'h0;
        state <= ST_IDLE;
        rd_shift <= 8'h00;
        op_kind <= OP_RESET;
        op_otp <= 1'b0;
        cnt <= 32'h0;
      end else begin
        state <= ST_IDLE;
      end
      cur_cmd <= 8'h00;
      pidx <= 2'h0;
      entry_direction <= `EPD_RST_ENTRY;
      hv_detect_setup <= `EPD_RST_HVDET;
      supply_level_o <= `EPD_RST_SUPPLY;
      temp_ext_o <= 1'b1;
      temperature_value <= `EPD_RST_TEMP;
      ext_sensor_command_o <= `EPD_RST_EXTS;
      update_ram_option <= `EPD_RST_RAMOPT;
      update_sequence_option <= `EPD_RST_SEQOPT;
      cascade_link_pin_o <= 1'b0;
      otp_internal <= 1'b0;
      hv_flag <= 1'b0;
      low_flag <= 1'b0;
      clock_on_stage_o <= 1'b0;
      analog_on_stage_o <= 1'b0;
      active_stage_o <= 8'h00;
      display_bw_mode_o <= 1'b0;
      otp_prog_o <= 1'b0;
      otp_area_o <= 8'h00;
      i2c_start_o <= 1'b0;
      ram_we_o <= 1'b0;
      ram_x_o <= 6'h00;
      ram_y_o <= 9'h000;
      ram_wdata_o <= 8'h00;
      seq_mask <= 8'h00;
      sidx <= 3'h7;
      hv_loops <= 3'h0;
    end else begin
      ram_we_o <= 1'b0;
      i2c_start_o <= 1'b0;
      // The fall that closes a byte leaves a freshly loaded reply intact.
      if (!cs_n_s && sclk_fall && bit_cnt != 3'h0) begin
        rd_shift <= {rd_shift[6:0], 1'b0};
      end
      case (state)
        ST_IDLE: begin
          if (pop && !dflag) begin
            cur_cmd <= dbyte;
            pidx <= 2'h0;
            case (dbyte)
              `EPD_CMD_SWRST: begin
                state <= ST_TIMED;
                op_kind <= OP_RESET;
                cnt <= `EPD_RST_CYC;
              end
              `EPD_CMD_TRD: begin
                rd_shift <= temperature_value;
              end
              `EPD_CMD_STATUS: begin
                rd_shift <= {2'h0, hv_flag, low_flag, 1'b0, busy_o, CHIP_ID};
              end
              `EPD_CMD_ACTIVATE: begin
                state <= ST_SEQ;
                seq_mask <= update_sequence_option;
                display_bw_mode_o <= update_sequence_option[3];
                op_otp <= 1'b0;
                sidx <= 3'h7;
                cnt <= 32'h0;
              end
              default: begin
              end
            endcase
          end else if (pop) begin
            pidx <= (pidx == 2'h3) ? 2'h3 : pidx + 2'h1;
            case (cur_cmd)
              `EPD_CMD_SLEEP: begin
                if (dbyte[0]) begin
                  sleep_mode_o <= dbyte[1:0];
                  state <= ST_SLEEP;
                end
              end
              `EPD_CMD_ENTRY: entry_direction <= dbyte[2:0];
              `EPD_CMD_HVDET: begin
                hv_detect_setup <= dbyte;
                if (clock_on_stage_o && analog_on_stage_o) begin
                  state <= ST_HV;
                  cnt <= COOL_CYC * ({29'h0, dbyte[6:4]} + 32'h1);
                  hv_loops <= dbyte[2:0];
                end
              end
              `EPD_CMD_SUPPLY: begin
                supply_level_o <= dbyte[2:0];
                if (clock_on_stage_o && analog_on_stage_o &&
                    dbyte[2]) begin
                  state <= ST_TIMED;
                  op_kind <= OP_SUPPLY;
                  cnt <= `EPD_DET_CYC;
                end
              end
              `EPD_CMD_PWPROG: begin
                if (clock_on_stage_o) begin
                  state <= ST_TIMED;
                  op_kind <= OP_PW;
                  otp_area_o <= `EPD_CMD_PWPROG;
                  otp_prog_o <= 1'b1;
                  cnt <= `EPD_OTP_CYC;
                end
              end
              `EPD_CMD_AUTOPROG: begin
                if (otp_internal && (dbyte == 8'h08 || dbyte == 8'h16 ||
                    dbyte == 8'h2A || dbyte == 8'h30 || dbyte == 8'h36)) begin
                  state <= ST_SEQ;
                  seq_mask <= `EPD_AUTO_SEQ;
                  op_otp <= 1'b1;
                  otp_area_o <= dbyte;
                  sidx <= 3'h7;
                  cnt <= 32'h0;
                end
              end
              `EPD_CMD_TSRC: temp_ext_o <= (dbyte != `EPD_TSRC_INT);
              `EPD_CMD_TWR: temperature_value <= dbyte;
              `EPD_CMD_EXTS: begin
                case (pidx)
                  2'h0: ext_sensor_command_o[23:16] <= dbyte;
                  2'h1: ext_sensor_command_o[15:8] <= dbyte;
                  default: ext_sensor_command_o[7:0] <= dbyte;
                endcase
                if (pidx == 2'h2 && clock_on_stage_o) begin
                  state <= ST_I2C;
                  i2c_start_o <= 1'b1;
                end
              end
              `EPD_CMD_RAMOPT: begin
                if (pidx == 2'h0) begin
                  update_ram_option[15:8] <= dbyte;
                end else if (pidx == 2'h1) begin
                  update_ram_option[7:0] <= dbyte;
                  cascade_link_pin_o <= dbyte[4];
                end
              end
              `EPD_CMD_SEQOPT: update_sequence_option <= dbyte;
              `EPD_CMD_PROGMODE: otp_internal <= (dbyte[1:0] == 2'h3);
              `EPD_CMD_WRBW: begin
                ram_we_o <= 1'b1;
                ram_wdata_o <= dbyte;
                if (!entry_direction[2]) begin
                  ram_x_o <= x_next[5:0];
                  if (x_next == x_wrap) begin
                    ram_y_o <= y_next;
                  end
                end else begin
                  ram_y_o <= y_next;
                  if (y_next == y_wrap) begin
                    ram_x_o <= x_next[5:0];
                  end
                end
              end
              default: begin
              end
            endcase
          end
        end
        ST_TIMED: begin
          if (cnt != 32'h0) begin
            cnt <= cnt - 32'h1;
          end else begin
            state <= ST_IDLE;
            otp_prog_o <= 1'b0;
            if (op_kind == OP_SUPPLY) begin
              low_flag <= supply_low_i;
            end
          end
        end
        ST_HV: begin
          if (cnt > 32'h1) begin
            cnt <= cnt - 32'h1;
          end else if (hv_ready_i) begin
            hv_flag <= 1'b0;
            state <= ST_IDLE;
          end else if (hv_loops <= 3'h1) begin
            hv_flag <= 1'b1;
            state <= ST_IDLE;
          end else begin
            hv_loops <= hv_loops - 3'h1;
            cnt <= cool_len;
          end
        end
        ST_SEQ: begin
          // Stage three is passed over in one cycle; the colour mode is set only when Activate starts the sequence, not for auto programming.
          if (!seq_mask[sidx] || sidx == 3'h3) begin
            active_stage_o <= 8'h00;
            sidx <= sidx - 3'h1;
            cnt <= 32'h0;
            if (sidx == 3'h0) begin
              state <= ST_IDLE;
            end
          end else if (cnt + 32'h1 < stage_len) begin
            cnt <= cnt + 32'h1;
            active_stage_o <= 8'h01 << sidx;
            otp_prog_o <= op_otp && (sidx == 3'h2);
          end else begin
            cnt <= 32'h0;
            active_stage_o <= 8'h00;
            otp_prog_o <= 1'b0;
            case (sidx)
              3'h7: clock_on_stage_o <= 1'b1;
              3'h6: analog_on_stage_o <= 1'b1;
              3'h5: begin
                if (!temp_ext_o) begin
                  temperature_value <= int_temp_i;
                end
              end
              3'h1: analog_on_stage_o <= 1'b0;
              3'h0: clock_on_stage_o <= 1'b0;
              default: begin
              end
            endcase
            sidx <= sidx - 3'h1;
            if (sidx == 3'h0) begin
              state <= ST_IDLE;
            end
          end
        end
        ST_I2C: begin
          if (i2c_done_i) begin
            state <= ST_IDLE;
          end
        end
        ST_SLEEP: begin
          state <= ST_SLEEP;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // epd_cmd_top

`default_nettype wire

/* rtl/epd_fifo.v */
`timescale 1ns/10ps
`default_nettype none

module epd_fifo #(
  parameter W = 9,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready_o = (count != D[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // epd_fifo

`default_nettype wire

/* tb/epd_cmd_top_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------
// Port checks
// ----------
module epd_cmd_props (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic busy_o,
  input wire logic [1:0] sleep_mode_o,
  input wire logic clock_on_stage_o,
  input wire logic analog_on_stage_o,
  input wire logic [7:0] active_stage_o,
  input wire logic otp_prog_o,
  input wire logic temp_ext_o,
  input wire logic [2:0] supply_level_o,
  input wire logic ram_we_o,
  input wire logic [5:0] ram_x_o,
  input wire logic [8:0] ram_y_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_SLEEP_BUSY: assert property (
    sleep_mode_o != 2'h0 |-> ##1 busy_o) else $error("busy low in sleep");
  AST_RESET_VALUES: assert property (
    $fell(sys_rst_i) |-> temp_ext_o && supply_level_o == 3'h4 && !busy_o)
    else $error("wrong values after reset");
  AST_WRITE_PULSE: assert property (
    ram_we_o |=> !ram_we_o) else $error("write strobe too long");
  AST_ADDR_RANGE: assert property (
    ram_we_o |-> ram_x_o <= 6'h31 && ram_y_o <= 9'h12B)
    else $error("address out of range");
  AST_ONE_STAGE: assert property (
    $onehot0(active_stage_o)) else $error("several stages at once");
  AST_ANALOG_CLOCK: assert property (
    analog_on_stage_o |-> clock_on_stage_o) else $error("analog without clock");
  AST_PROG_CLOCK: assert property (
    otp_prog_o |-> clock_on_stage_o) else $error("programming without clock");
  AST_STAGE_BUSY: assert property (
    active_stage_o != 8'h00 |=> busy_o) else $error("busy low in sequence");
endmodule // epd_cmd_props
bind epd_cmd_top epd_cmd_props u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .busy_o(busy_o), .sleep_mode_o(sleep_mode_o),
  .clock_on_stage_o(clock_on_stage_o), .analog_on_stage_o(analog_on_stage_o),
  .active_stage_o(active_stage_o), .otp_prog_o(otp_prog_o),
  .temp_ext_o(temp_ext_o), .supply_level_o(supply_level_o),
  .ram_we_o(ram_we_o), .ram_x_o(ram_x_o), .ram_y_o(ram_y_o));
`default_nettype wire

/* tb/epd_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------
// Host side of the serial link
// ----------
module epd_host_model (
  input wire logic clk_i,
  input wire logic miso_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic mosi_o,
  output logic dc_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    dc_o = 1'b0;
  end
  task automatic send(input logic d, input logic [7:0] b,
                      output logic [7:0] r);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    dc_o = d;
    for (int i = 7; i >= 0; i--) begin
      mosi_o = b[i];
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b1;
      r[i] = miso_i;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    repeat (8) @(negedge clk_i);
  endtask
endmodule // epd_host_model
`default_nettype wire

/* tb/tb_epd_control_command_set.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module tb_epd_control_command_set;
  logic clk, rst, hv, low, idone, dbw, dred, cs_n, sclk, mosi, dc, miso;
  logic busy, ck, an, bwm, casc, otp, text, i2s, we, obw, ored;
  logic [1:0] slp;
  logic [2:0] lvl;
  logic [5:0] rx, wx;
  logic [8:0] ry, wy;
  logic [7:0] stg, area, rwd, wd, rd, v, itemp;
  logic [23:0] ext;
  logic saw_an, saw_otp, saw_i2c;
  int bad_count, check_count;
  epd_host_model host (.clk_i(clk), .miso_i(miso), .cs_n_o(cs_n),
    .sclk_o(sclk), .mosi_o(mosi), .dc_o(dc));
  epd_cmd_top #(.COOL_CYC(20), .STEP_CYC(4), .DISP_CYC(4)) uut (
    .clk_i(clk), .sys_rst_i(rst), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk),
    .spi_mosi_i(mosi), .spi_dc_i(dc), .spi_miso_o(miso), .hv_ready_i(hv),
    .supply_low_i(low), .i2c_done_i(idone), .int_temp_i(itemp),
    .disp_bw_i(dbw), .disp_red_i(dred), .disp_bw_o(obw), .disp_red_o(ored),
    .busy_o(busy), .sleep_mode_o(slp), .clock_on_stage_o(ck),
    .analog_on_stage_o(an), .active_stage_o(stg), .display_bw_mode_o(bwm),
    .cascade_link_pin_o(casc), .otp_prog_o(otp), .otp_area_o(area),
    .supply_level_o(lvl), .temp_ext_o(text), .i2c_start_o(i2s),
    .ext_sensor_command_o(ext), .ram_we_o(we), .ram_x_o(rx), .ram_y_o(ry),
    .ram_wdata_o(rwd), .spi_overrun_o());
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------
  // Output capture
  // ----------
  always @(posedge clk) begin
    if (we) begin
      wx <= rx;
      wy <= ry;
      wd <= rwd;
    end
    if (an) saw_an <= 1'b1;
    if (otp) saw_otp <= 1'b1;
    if (i2s) saw_i2c <= 1'b1;
  end
  task cmd(input logic [7:0] c); host.send(1'b0, c, rd); endtask
  task par(input logic [7:0] p); host.send(1'b1, p, rd); endtask
  task rdb(input logic [7:0] c);
    cmd(c);
    repeat (10) @(negedge clk);
    host.send(1'b1, 8'h00, v);
  endtask
  task waitb;
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 3000) begin
      @(negedge clk);
      i++;
    end
    `CHK(busy, 1'b0)
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task t_ram;
    cmd(8'h11); par(8'h03); cmd(8'h24); par(8'hA5);
    `CHK(wd, 8'hA5)
    `CHK({wy, wx}, {9'h000, 6'h01})
    cmd(8'h11); par(8'h07); cmd(8'h24); par(8'h3C);
    `CHK({wy, wx, wd}, {9'h001, 6'h01, 8'h3C})
    $display("ram done");
  endtask
  task t_seq;
    cmd(8'h22); par(8'hC7); cmd(8'h20);
    `CHK(busy, 1'b1)
    waitb;
    `CHK({saw_an, ck, bwm}, 3'b100)
    cmd(8'h22); par(8'hC0); cmd(8'h20); waitb;
    `CHK({ck, an}, 2'b11)
    $display("sequence done");
  endtask
  task t_det;
    low = 1'b1;
    cmd(8'h15); par(8'h05); waitb;
    `CHK(lvl, 3'h5)
    rdb(8'h2F);
    `CHK({v[4], v[1:0]}, 3'b101)
    for (int i = 0; i < 2; i++) begin
      hv = i[0];
      cmd(8'h14); par(8'h00); waitb; rdb(8'h2F);
      `CHK(v[5], ~hv)
    end
    cmd(8'h16); par(8'hA5); waitb;
    `CHK(saw_otp, 1'b1)
    cmd(8'h1C); par(8'h40); par(8'h12); par(8'h34);
    `CHK({saw_i2c, busy}, 2'b11)
    `CHK(ext, 24'h401234)
    idone = 1'b1;
    waitb;
    idone = 1'b0;
    $display("detect done");
  endtask
  task t_auto;
    cmd(8'h17); par(8'h30);
    `CHK({busy, area}, {1'b0, 8'h16})
    cmd(8'h39); par(8'h03); cmd(8'h17); par(8'h11);
    `CHK({busy, area}, {1'b0, 8'h16})
    cmd(8'h17); par(8'h30);
    `CHK(busy, 1'b1)
    waitb;
    `CHK({area, ck, an}, {8'h30, 2'b00})
    $display("auto program done");
  endtask
  task t_opt;
    logic [3:0] o;
    for (int k = 0; k < 6; k++) begin
      o = 4'(4 * (k / 2));
      cmd(8'h21); par({o, o}); par(8'h10);
      dbw = k[0];
      dred = ~k[0];
      repeat (3) @(negedge clk);
      `CHK(obw, o == 4'h8 ? ~k[0] : (o == 4'h4 ? 1'b0 : k[0]))
      `CHK(ored, o == 4'h8 ? k[0] : (o == 4'h4 ? 1'b0 : ~k[0]))
    end
    `CHK(casc, 1'b1)
    $display("option done");
  endtask
  task t_rst;
    cmd(8'h18); par(8'h80);
    `CHK(text, 1'b0)
    cmd(8'h1A); par(8'h5A); rdb(8'h1B);
    `CHK(v, 8'h5A)
    itemp = 8'h3C;
    cmd(8'h22); par(8'hB1); cmd(8'h20); waitb; rdb(8'h1B);
    `CHK(v, 8'h3C)
    cmd(8'h12);
    `CHK(busy, 1'b1)
    waitb;
    `CHK({text, lvl, casc}, 5'b11000)
    rdb(8'h1B);
    `CHK(v, 8'h7F)
    $display("soft reset done");
  endtask
  task t_sleep;
    for (int s = 1; s < 4; s += 2) begin
      cmd(8'h10); par(8'(s));
      `CHK({slp, busy}, {2'(s), 1'b1})
      rst = 1'b1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      `CHK(slp, 2'h0)
    end
    $display("sleep done");
  endtask
  initial begin
    {rst, hv, low, idone, dbw, dred, saw_an, saw_otp, saw_i2c} = 9'h100;
    itemp = 8'h00;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    `CHK({text, lvl}, 4'hC)
    t_ram; t_seq; t_det; t_auto; t_opt; t_rst; t_sleep;
    results;
  end
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    results;
  end
endmodule // tb_epd_control_command_set
`default_nettype wire
